// ### core/port_pin_function_select.sv
// Pin function selector for ports B, C and D with an AHB-Lite register slave.
//
// How it works
// - Port B: eight pins, per-bit pull-up.
// - Port C: seven pins, per-bit pull-up.
// - Port D: eight pins, per-bit pull-up.
// - Any reset floats every port pin.
// - Fuse programmed: port C bit six is I/O.
// - Fuse unprogrammed: bit six is reset input.
// - Low longer than minimum pulse causes reset.
// - Crystal fuse: B six feeds oscillator input.
// - Crystal fuse: B seven is amplifier output.
// - Internal RC plus async bit, crystal fuse clear: timer oscillator.
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defines.svh"

module port_pin_function_select
  import pin_select_pkg::*;
#(
  parameter int RESET_MIN_PULSE_CYC = `RESET_MIN_PULSE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic reset_pin_disable_fuse,
  input wire logic crystal_clock_fuse,
  input wire logic internal_rc_clock_fuse,
  input wire logic [7:0] port_b_pins_in,
  output logic [7:0] port_b_pins_out,
  output logic [7:0] port_b_pins_oe,
  output logic [7:0] port_b_pullup,
  input wire logic [5:0] port_c_low_pins_in,
  output logic [5:0] port_c_low_pins_out,
  output logic [5:0] port_c_low_pins_oe,
  input wire logic port_c_bit_six_pin_in,
  output logic port_c_bit_six_pin_out,
  output logic port_c_bit_six_pin_oe,
  output logic [6:0] port_c_pullup,
  input wire logic [7:0] port_d_pins_in,
  output logic [7:0] port_d_pins_out,
  output logic [7:0] port_d_pins_oe,
  output logic [7:0] port_d_pullup,
  output logic osc_amp_enable,
  output logic timer_osc_enable,
  output logic ext_reset_req
);

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(RESET_MIN_PULSE_CYC - 1);

  // Pin and fuse inputs come from outside the clock domain.
  logic [25:0] sync_q;
  fuse_s fuse_sync;
  port_set_s pin_sync;

  sync_two_ff #(
    .WIDTH(26)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({reset_pin_disable_fuse, crystal_clock_fuse, internal_rc_clock_fuse,
        port_b_pins_in, port_c_bit_six_pin_in, port_c_low_pins_in, port_d_pins_in}),
    .q(sync_q)
  );

  assign fuse_sync = sync_q[25:23];
  assign pin_sync = sync_q[22:0];

  // Fuse capture after the synchroniser has settled.
  fuse_s fuse_ff;
  logic loaded_ff;
  logic [1:0] settle_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      settle_ff <= 2'h0;
      loaded_ff <= 1'b0;
      fuse_ff <= '0;
    end
    else if (!loaded_ff)
    begin
      settle_ff <= settle_ff + 2'h1;
      if (settle_ff == 2'(`FUSE_SETTLE_CYC - 1))
      begin
        loaded_ff <= 1'b1;
        fuse_ff <= fuse_sync;
      end
    end
  end

  // Pin function selection.
  logic ctrl_async_ff;
  logic osc_pins;
  logic timer_pins;
  logic pc6_is_reset;
  reset_filter_e rst_state_ff;
  logic hold_z;
  port_set_s special_mask;

  assign osc_pins = loaded_ff & fuse_ff.crystal_osc;
  assign timer_pins = loaded_ff & fuse_ff.internal_rc & ~fuse_ff.crystal_osc & ctrl_async_ff;
  assign pc6_is_reset = ~fuse_ff.reset_pin_disable;
  assign hold_z = ~loaded_ff | (rst_state_ff == RST_ACTIVE);

  always_comb
  begin
    special_mask = '0;
    special_mask.b[7:6] = {2{osc_pins | timer_pins}};
    special_mask.c[6] = pc6_is_reset;
  end

  // External reset filter on port C bit six.
  logic [CNT_W-1:0] pulse_cnt_ff;
  logic pc6_low;

  assign pc6_low = loaded_ff & pc6_is_reset & ~pin_sync.c[6];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_state_ff <= RST_IDLE;
      pulse_cnt_ff <= '0;
    end
    else
    begin
      case (rst_state_ff)
        RST_IDLE:
        begin
          pulse_cnt_ff <= '0;
          if (pc6_low)
            rst_state_ff <= RST_LOW;
        end
        RST_LOW:
        begin
          if (!pc6_low)
            rst_state_ff <= RST_IDLE;
          else if (pulse_cnt_ff >= PULSE_LAST)
            rst_state_ff <= RST_ACTIVE;
          else
            pulse_cnt_ff <= pulse_cnt_ff + CNT_W'(1);
        end
        RST_ACTIVE:
        begin
          if (!pc6_low)
            rst_state_ff <= RST_IDLE;
        end
        default:
          rst_state_ff <= RST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ext_reset_req <= 1'b0;
    else
      ext_reset_req <= (rst_state_ff == RST_ACTIVE);
  end

  // AHB-Lite slave.
  logic sel_addr;
  logic wr_pend_ff;
  logic [`ADDR_W-1:0] wr_addr_ff;
  logic ext_seen_ff;
  port_set_s dir_ff;
  port_set_s out_ff;
  port_set_s in_view;
  logic [31:0] rd_word;

  assign sel_addr = hsel & hready & (htrans == `HTRANS_NONSEQ);
  assign in_view = pin_sync & ~special_mask;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end
    else if (hready)
    begin
      wr_pend_ff <= sel_addr & hwrite;
      wr_addr_ff <= haddr[`ADDR_W-1:0];
    end
  end

  always_comb
  begin
    rd_word = 32'h00000000;
    if (haddr[`ADDR_W-1:0] == `OFS_B_DIR)
      rd_word[7:0] = dir_ff.b;
    else if (haddr[`ADDR_W-1:0] == `OFS_B_OUT)
      rd_word[7:0] = out_ff.b;
    else if (haddr[`ADDR_W-1:0] == `OFS_B_IN)
      rd_word[7:0] = in_view.b;
    else if (haddr[`ADDR_W-1:0] == `OFS_C_DIR)
      rd_word[6:0] = dir_ff.c;
    else if (haddr[`ADDR_W-1:0] == `OFS_C_OUT)
      rd_word[6:0] = out_ff.c;
    else if (haddr[`ADDR_W-1:0] == `OFS_C_IN)
      rd_word[6:0] = in_view.c;
    else if (haddr[`ADDR_W-1:0] == `OFS_D_DIR)
      rd_word[7:0] = dir_ff.d;
    else if (haddr[`ADDR_W-1:0] == `OFS_D_OUT)
      rd_word[7:0] = out_ff.d;
    else if (haddr[`ADDR_W-1:0] == `OFS_D_IN)
      rd_word[7:0] = in_view.d;
    else if (haddr[`ADDR_W-1:0] == `OFS_CTRL)
      rd_word[`CTRL_ASYNC_BIT] = ctrl_async_ff;
    else if (haddr[`ADDR_W-1:0] == `OFS_STATUS)
    begin
      rd_word[`ST_RESET_PIN_DISABLE_BIT] = fuse_ff.reset_pin_disable;
      rd_word[`ST_CRYSTAL_BIT] = fuse_ff.crystal_osc;
      rd_word[`ST_INTERNAL_RC_BIT] = fuse_ff.internal_rc;
      rd_word[`ST_OSC_AMP_BIT] = osc_pins;
      rd_word[`ST_TIMER_OSC_BIT] = timer_pins;
      rd_word[`ST_LOADED_BIT] = loaded_ff;
      rd_word[`ST_EXT_RESET_BIT] = ext_seen_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (sel_addr && !hwrite)
      hrdata <= rd_word;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Port registers return to reset values while the pin reset is active.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dir_ff <= `DIR_RESET;
      out_ff <= `OUT_RESET;
      ctrl_async_ff <= `CTRL_RESET;
    end
    else if (rst_state_ff == RST_ACTIVE)
    begin
      dir_ff <= `DIR_RESET;
      out_ff <= `OUT_RESET;
      ctrl_async_ff <= `CTRL_RESET;
    end
    else if (wr_pend_ff)
    begin
      if (wr_addr_ff == `OFS_B_DIR)
        dir_ff.b <= hwdata[7:0];
      else if (wr_addr_ff == `OFS_B_OUT)
        out_ff.b <= hwdata[7:0];
      else if (wr_addr_ff == `OFS_C_DIR)
        dir_ff.c <= hwdata[6:0];
      else if (wr_addr_ff == `OFS_C_OUT)
        out_ff.c <= hwdata[6:0];
      else if (wr_addr_ff == `OFS_D_DIR)
        dir_ff.d <= hwdata[7:0];
      else if (wr_addr_ff == `OFS_D_OUT)
        out_ff.d <= hwdata[7:0];
      else if (wr_addr_ff == `OFS_CTRL)
        ctrl_async_ff <= hwdata[`CTRL_ASYNC_BIT];
    end
  end

  // Sticky flag for a filtered external reset; a new event beats a clear.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ext_seen_ff <= 1'b0;
    else if (rst_state_ff == RST_ACTIVE)
      ext_seen_ff <= 1'b1;
    else if (wr_pend_ff && wr_addr_ff == `OFS_STATUS && hwdata[`ST_EXT_RESET_BIT])
      ext_seen_ff <= 1'b0;
  end

  // Pin drivers, all registered.
  port_set_s nxt_oe;
  port_set_s nxt_out;
  port_set_s nxt_pullup;

  always_comb
  begin
    if (hold_z)
    begin
      nxt_oe = '0;
      nxt_out = '0;
      nxt_pullup = '0;
    end
    else
    begin
      nxt_oe = dir_ff & ~special_mask;
      nxt_out = out_ff & ~special_mask;
      nxt_pullup = ~dir_ff & out_ff & ~special_mask;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_b_pins_oe <= 8'h00;
      port_b_pins_out <= 8'h00;
      port_b_pullup <= 8'h00;
      port_c_low_pins_oe <= 6'h00;
      port_c_low_pins_out <= 6'h00;
      port_c_bit_six_pin_oe <= 1'b0;
      port_c_bit_six_pin_out <= 1'b0;
      port_c_pullup <= 7'h00;
      port_d_pins_oe <= 8'h00;
      port_d_pins_out <= 8'h00;
      port_d_pullup <= 8'h00;
    end
    else
    begin
      port_b_pins_oe <= nxt_oe.b;
      port_b_pins_out <= nxt_out.b;
      port_b_pullup <= nxt_pullup.b;
      port_c_low_pins_oe <= nxt_oe.c[5:0];
      port_c_low_pins_out <= nxt_out.c[5:0];
      port_c_bit_six_pin_oe <= nxt_oe.c[6];
      port_c_bit_six_pin_out <= nxt_out.c[6];
      port_c_pullup <= nxt_pullup.c;
      port_d_pins_oe <= nxt_oe.d;
      port_d_pins_out <= nxt_out.d;
      port_d_pullup <= nxt_pullup.d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_amp_enable <= 1'b0;
      timer_osc_enable <= 1'b0;
    end
    else
    begin
      osc_amp_enable <= osc_pins;
      timer_osc_enable <= timer_pins;
    end
  end

  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_pulse_done;
    (rst_state_ff == RST_LOW) && (pulse_cnt_ff >= PULSE_LAST) && pc6_low;
  endsequence

  sequence s_filter_fires;
    s_pulse_done ##1 (rst_state_ff == RST_ACTIVE);
  endsequence

  chk_reset_floats: assert property (hold_z |=> (port_b_pins_oe == 8'h00) &&
      (port_c_low_pins_oe == 6'h00) && !port_c_bit_six_pin_oe && (port_d_pins_oe == 8'h00))
    else $error("port pin driven during reset");

  chk_port_b_pullup: assert property (!hold_z |=> port_b_pullup ==
      $past(~dir_ff.b & out_ff.b & ~special_mask.b))
    else $error("port b pull-up mismatch");

  chk_port_c_pullup: assert property (!hold_z |=> port_c_pullup[5:0] ==
      $past(~dir_ff.c[5:0] & out_ff.c[5:0]))
    else $error("port c pull-up mismatch");

  chk_port_d_drive: assert property (!hold_z |=> (port_d_pins_oe == $past(dir_ff.d)) &&
      (port_d_pullup == $past(~dir_ff.d & out_ff.d)))
    else $error("port d drive mismatch");

  chk_pc6_gpio_drive: assert property (loaded_ff && fuse_ff.reset_pin_disable && !hold_z
      |=> port_c_bit_six_pin_oe == $past(dir_ff.c[6]))
    else $error("port c bit six not following direction");

  chk_pc6_reset_input: assert property (loaded_ff && !fuse_ff.reset_pin_disable
      |=> !port_c_bit_six_pin_oe && !port_c_pullup[6])
    else $error("port c bit six driven while reset input");

  chk_pulse_length: assert property ($rose(rst_state_ff == RST_ACTIVE) |->
      $past(pulse_cnt_ff) == PULSE_LAST)
    else $error("reset taken before minimum pulse");

  chk_filter_request: assert property (s_filter_fires |=> ext_reset_req)
    else $error("filtered reset not requested");

  chk_short_pulse: assert property ((rst_state_ff == RST_LOW) && !pc6_low |=>
      (rst_state_ff == RST_IDLE) ##1 !ext_reset_req)
    else $error("short pulse produced reset");

  chk_osc_pins: assert property (osc_pins |=> osc_amp_enable &&
      (port_b_pins_oe[7:6] == 2'h0) && (port_b_pullup[7:6] == 2'h0))
    else $error("oscillator pins not released");

  chk_timer_osc: assert property (timer_pins |=> timer_osc_enable &&
      (port_b_pins_oe[7:6] == 2'h0))
    else $error("timer oscillator pins not released");

  chk_fuse_stable: assert property (loaded_ff |=> loaded_ff && $stable(fuse_ff))
    else $error("fuse snapshot changed");

endmodule
`default_nettype wire

// ### core/pin_select_defines.svh
// Offsets, field positions, reset values and timing counts of the pin function selector.
`ifndef PIN_SELECT_DEFINES_SVH
`define PIN_SELECT_DEFINES_SVH

`define ADDR_W 8
`define HTRANS_NONSEQ 2'h2

`define OFS_B_DIR 8'h00
`define OFS_B_OUT 8'h04
`define OFS_B_IN 8'h08
`define OFS_C_DIR 8'h0c
`define OFS_C_OUT 8'h10
`define OFS_C_IN 8'h14
`define OFS_D_DIR 8'h18
`define OFS_D_OUT 8'h1c
`define OFS_D_IN 8'h20
`define OFS_CTRL 8'h24
`define OFS_STATUS 8'h28

`define DIR_RESET 23'h000000
`define OUT_RESET 23'h000000
`define CTRL_RESET 1'h0

`define CTRL_ASYNC_BIT 0
`define ST_RESET_PIN_DISABLE_BIT 0
`define ST_CRYSTAL_BIT 1
`define ST_INTERNAL_RC_BIT 2
`define ST_OSC_AMP_BIT 3
`define ST_TIMER_OSC_BIT 4
`define ST_LOADED_BIT 5
`define ST_EXT_RESET_BIT 6

`define CLK_PERIOD_NS 8
`define RESET_MIN_PULSE_NS 1000
`define RESET_MIN_PULSE_CYC ((`RESET_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FUSE_SETTLE_CYC 3

`endif

// ### core/pin_select_pkg.sv
// Types shared by the pin function selector.
package pin_select_pkg;

  typedef struct packed {
    logic reset_pin_disable;
    logic crystal_osc;
    logic internal_rc;
  } fuse_s;

  typedef struct packed {
    logic [7:0] b;
    logic [6:0] c;
    logic [7:0] d;
  } port_set_s;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_LOW = 2'b01,
    RST_ACTIVE = 2'b11
  } reset_filter_e;

endpackage

// ### core/sync_two_ff.sv
// Two flip-flop synchroniser for a vector of independent levels.
`timescale 1ns/1ps
`default_nettype none

module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_ff <= '0;
      q <= '0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ### tb/board_model.sv
// Board model: pad levels from device drive, external drivers, pull-ups and floating nets.
`timescale 1ns/1ps
`default_nettype none
module board_model
  import pin_select_pkg::*;
(
  input wire logic hclk,
  input wire port_set_s dev_out,
  input wire port_set_s dev_oe,
  input wire port_set_s dev_pull,
  input wire port_set_s ext_en,
  input wire port_set_s ext_val,
  output port_set_s pad
);
  port_set_s flt_ff = '0;
  // An undriven, unpulled net shows a level that changes every cycle.
  always_ff @(posedge hclk)
  begin
    flt_ff <= ~flt_ff;
  end
  // The reset source holds port C bit six low for as long as the bench asks.
  assign pad = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val) | (~dev_oe & ~ext_en & (dev_pull | flt_ff));
endmodule
`default_nettype wire

// ### tb/port_pin_function_select_tb_top.sv
// Testbench of the pin function selector, with AHB-Lite master tasks.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defines.svh"
module port_pin_function_select_tb_top
  import pin_select_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, osc_amp_enable, timer_osc_enable, ext_reset_req;
  logic [31:0] hrdata;
  fuse_s fuse = '0;
  // Each port of the device drives only its own slice of these sets, so they are nets.
  wire port_set_s dev_out, dev_oe, dev_pull;
  port_set_s pad;
  port_set_s ext_en = 23'h004000;
  port_set_s ext_val = 23'h004000;
  int miscompares = 0;
  int total_checks = 0;

  always #4 hclk = ~hclk;

  port_pin_function_select #(.RESET_MIN_PULSE_CYC(4)) port_pin_function_select_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .reset_pin_disable_fuse(fuse.reset_pin_disable), .crystal_clock_fuse(fuse.crystal_osc),
    .internal_rc_clock_fuse(fuse.internal_rc),
    .port_b_pins_in(pad.b), .port_b_pins_out(dev_out.b), .port_b_pins_oe(dev_oe.b), .port_b_pullup(dev_pull.b),
    .port_c_low_pins_in(pad.c[5:0]), .port_c_low_pins_out(dev_out.c[5:0]), .port_c_low_pins_oe(dev_oe.c[5:0]),
    .port_c_bit_six_pin_in(pad.c[6]), .port_c_bit_six_pin_out(dev_out.c[6]),
    .port_c_bit_six_pin_oe(dev_oe.c[6]), .port_c_pullup(dev_pull.c),
    .port_d_pins_in(pad.d), .port_d_pins_out(dev_out.d), .port_d_pins_oe(dev_oe.d), .port_d_pullup(dev_pull.d),
    .osc_amp_enable(osc_amp_enable), .timer_osc_enable(timer_osc_enable), .ext_reset_req(ext_reset_req)
  );

  board_model board_model_i (
    .hclk(hclk), .dev_out(dev_out), .dev_oe(dev_oe), .dev_pull(dev_pull),
    .ext_en(ext_en), .ext_val(ext_val), .pad(pad)
  );

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("CHECK FAILED at %0t: timeout on %s", $time, what);
    give_verdict();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100)
      hang("hready");
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    check(x, exp, what);
  endtask

  task automatic wait_req(input logic v);
    int n;
    n = 0;
    while (ext_reset_req !== v && n < 40)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 40)
      hang("pin reset");
  endtask

  function automatic logic [7:0] pick(input port_set_s s, input int sel);
    return sel == 0 ? s.b : sel == 1 ? {1'b0, s.c} : s.d;
  endfunction

  task automatic do_reset(input fuse_s f);
    hresetn <= 1'b0;
    fuse <= f;
    tick(2);
    check(dev_oe, 32'h0, "oe in reset");
    check(dev_pull, 32'h0, "pull-up in reset");
    hresetn <= 1'b1;
    tick(6);
  endtask

  task automatic t_status;
    check(hreadyout, 32'h1, "hreadyout");
    check(hresp, 32'h0, "hresp");
    rd_chk(`OFS_STATUS, 32'h25, "status fuses");
    rd_chk(8'h30, 32'h0, "unmapped read");
  endtask

  task automatic t_port(input logic [7:0] base, input int sel, input logic [7:0] mask);
    rd_chk(base, 32'h0, "dir reset value");
    wr(base + 8'h4, 32'ha5);
    wr(base, 32'hff);
    tick(2);
    check(pick(dev_oe, sel), mask, "drive enable");
    check(pick(dev_out, sel), 8'ha5 & mask, "drive value");
    wr(base, 32'h0);
    wr(base + 8'h4, 32'hff);
    tick(2);
    check(pick(dev_pull, sel), mask, "pull-up");
    ext_en <= '1;
    ext_val <= {8'h3c, 7'h3c, 8'h3c};
    tick(4);
    rd_chk(base + 8'h8, 32'h3c & mask, "pad input");
    ext_en <= 23'h004000;
    ext_val <= 23'h004000;
    wr(base + 8'h4, 32'h0);
  endtask

  task automatic t_timer;
    wr(`OFS_B_OUT, 32'hff);
    wr(`OFS_B_DIR, 32'hff);
    wr(`OFS_CTRL, 32'h1);
    tick(2);
    check(timer_osc_enable, 32'h1, "timer osc on");
    check(dev_oe.b, 32'h3f, "timer pins released");
    rd_chk(`OFS_STATUS, 32'h35, "status timer osc");
    wr(`OFS_CTRL, 32'h0);
    tick(2);
    check(dev_oe.b, 32'hff, "timer pins back");
  endtask

  task automatic t_fuse;
    fuse <= 3'b111;
    tick(8);
    check(osc_amp_enable, 32'h0, "fuse change ignored");
    rd_chk(`OFS_STATUS, 32'h25, "status held");
    do_reset(3'b111);
    wr(`OFS_B_OUT, 32'hff);
    wr(`OFS_B_DIR, 32'hff);
    wr(`OFS_CTRL, 32'h1);
    tick(2);
    check(osc_amp_enable, 32'h1, "crystal pins");
    check(timer_osc_enable, 32'h0, "crystal priority");
    check(dev_oe.b, 32'h3f, "crystal pins released");
    check(dev_pull.b, 32'h0, "crystal pins no pull");
    rd_chk(`OFS_STATUS, 32'h2f, "status crystal");
  endtask

  task automatic t_ext_reset;
    do_reset(3'b001);
    wr(`OFS_C_OUT, 32'h7f);
    wr(`OFS_C_DIR, 32'h7f);
    wr(`OFS_B_OUT, 32'h55);
    wr(`OFS_B_DIR, 32'hff);
    tick(2);
    check(dev_oe.c, 32'h3f, "reset pin not driven");
    check(dev_pull.c[6], 32'h0, "reset pin no pull");
    ext_val <= 23'h0;
    tick(2);
    ext_val <= 23'h004000;
    tick(12);
    check(ext_reset_req, 32'h0, "short pulse ignored");
    rd_chk(`OFS_STATUS, 32'h24, "short pulse left no trace");
    ext_val <= 23'h0;
    wait_req(1'b1);
    tick(1);
    check(dev_oe, 32'h0, "pins float in pin reset");
    ext_val <= 23'h004000;
    wait_req(1'b0);
    tick(2);
    rd_chk(`OFS_B_DIR, 32'h0, "dir cleared by pin reset");
    rd_chk(`OFS_STATUS, 32'h64, "status pin reset seen");
    wr(`OFS_STATUS, 32'h40);
    rd_chk(`OFS_STATUS, 32'h24, "pin reset flag cleared");
  endtask

  initial
  begin
    #200000;
    hang("run");
  end

  initial
  begin
    @(posedge hclk);
    do_reset(3'b101);
    t_status();
    t_port(`OFS_B_DIR, 0, 8'hff);
    t_port(`OFS_C_DIR, 1, 8'h7f);
    t_port(`OFS_D_DIR, 2, 8'hff);
    t_timer();
    t_fuse();
    t_ext_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
